// >>> design/pvp_voice_port.sv
`include "pvp_consts.svh"

module pvp_voice_port (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic mclk_in,
   input wire logic frame_sync_in,
   input wire logic rx_voice_in,
   input wire pvp_pkg::pvp_cfg_t config_reg_zero,
   input wire logic [15:0] tx_word,
   output logic tx_voice_out,
   output logic tx_voice_oe,
   output logic [15:0] rx_word,
   output logic rx_valid
);
   import pvp_pkg::*;

   logic rst_s1;
   logic rst_n_sync;
   pvp_state_t st;
   pvp_state_t next_st;

   // Every field is listed so that a field added later cannot go without a reset value
   localparam pvp_state_t reset_state = '{
      mclk_s1: `PVP_BIT_RESET,
      mclk_s2: `PVP_BIT_RESET,
      mclk_s3: `PVP_BIT_RESET,
      fs_s1: `PVP_BIT_RESET,
      fs_s2: `PVP_BIT_RESET,
      fs_prev: `PVP_BIT_RESET,
      rx_s1: `PVP_BIT_RESET,
      rx_s2: `PVP_BIT_RESET,
      frm: `PVP_CFG_RESET,
      idx: `PVP_IDX_IDLE,
      tx_shift: `PVP_WORD_RESET,
      rx_shift: `PVP_WORD_RESET,
      rx_word: `PVP_WORD_RESET,
      rx_valid: `PVP_BIT_RESET,
      tx_out: `PVP_BIT_RESET,
      tx_oe: `PVP_BIT_RESET
   };

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_s1 <= 1'b0;
         rst_n_sync <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n_sync <= rst_s1;
      end
   end

   function automatic logic [9:0] frame_len(input pvp_mclk_t sel);
      logic [9:0] len;
      len = `PVP_FRAME_LEN_512K;
      case (sel)
         PVP_MCLK_1536K: len = `PVP_FRAME_LEN_1536K;
         PVP_MCLK_2048K: len = `PVP_FRAME_LEN_2048K;
         PVP_MCLK_2560K: len = `PVP_FRAME_LEN_2560K;
         default: len = `PVP_FRAME_LEN_512K;
      endcase
      return len;
   endfunction

   function automatic logic [9:0] slot_base(input logic [4:0] slot);
      return 10'(slot) << `PVP_SLOT_SHIFT;
   endfunction

   // Bit index of the last bit of a voice word within its slot
   function automatic logic [3:0] word_msb(input logic linear);
      return linear ? `PVP_MSB_LINEAR : `PVP_MSB_COMPANDED;
   endfunction

   // A linear word spans two adjacent slots; a slot past the frame end never opens
   function automatic logic in_slot(input logic [9:0] idx, input logic [4:0] slot,
                                    input logic linear, input pvp_mclk_t sel);
      logic [9:0] base;
      logic [9:0] len;
      base = slot_base(slot);
      len = linear ? `PVP_WORD_LINEAR : `PVP_WORD_COMPANDED;
      return (idx >= base) && (idx < base + len) && (idx < frame_len(sel));
   endfunction

   function automatic logic [3:0] slot_off(input logic [9:0] idx, input logic [4:0] slot);
      logic [9:0] diff;
      diff = idx - slot_base(slot);
      return diff[3:0];
   endfunction

   always_comb begin
      logic rise;
      logic fall;
      logic launch;
      logic sample;
      logic [3:0] off;
      logic [3:0] msb;
      logic [15:0] shifted;
      rise = 1'b0;
      fall = 1'b0;
      launch = 1'b0;
      sample = 1'b0;
      off = 4'h0;
      msb = 4'h0;
      shifted = 16'h0000;
      next_st = st;

      // Pins are asynchronous to clk; the first stage is never looked at
      next_st.mclk_s1 = mclk_in;
      next_st.mclk_s2 = st.mclk_s1;
      next_st.mclk_s3 = st.mclk_s2;
      next_st.fs_s1 = frame_sync_in;
      next_st.fs_s2 = st.fs_s1;
      next_st.rx_s1 = rx_voice_in;
      next_st.rx_s2 = st.rx_s1;
      next_st.rx_valid = 1'b0;

      rise = st.mclk_s2 & ~st.mclk_s3;
      fall = ~st.mclk_s2 & st.mclk_s3;
      // Successive launch edges are one master clock period apart, giving one bit per period
      if (config_reg_zero.fmt == PVP_FMT_REVERSE) begin
         launch = fall;
         sample = rise;
      end else begin
         launch = rise;
         sample = fall;
      end

      if (launch) begin
         next_st.fs_prev = st.fs_s2;
         if (st.fs_s2 && !st.fs_prev) begin
            // Slots, width, rate and the transmit word are frozen per frame, so a change to them
            // written mid-frame cannot tear a word in half; the launch and sample edges follow the live format
            next_st.frm = config_reg_zero;
            next_st.tx_shift = tx_word;
            if (config_reg_zero.fmt == PVP_FMT_DELAYED) begin
               next_st.idx = `PVP_IDX_PENDING;
            end else begin
               next_st.idx = 10'h000;
            end
         end else if (st.idx == `PVP_IDX_PENDING) begin
            next_st.idx = 10'h000;
         end else if (st.idx < frame_len(st.frm.mclk_sel)) begin
            next_st.idx = st.idx + 10'h001;
         end

         if (in_slot(next_st.idx, next_st.frm.tx_slot, next_st.frm.linear,
                     next_st.frm.mclk_sel)) begin
            off = slot_off(next_st.idx, next_st.frm.tx_slot);
            msb = word_msb(next_st.frm.linear);
            next_st.tx_out = next_st.tx_shift[msb - off];
            next_st.tx_oe = 1'b1;
         end else begin
            next_st.tx_out = 1'b0;
            next_st.tx_oe = 1'b0;
         end
      end

      if (sample && in_slot(st.idx, st.frm.rx_slot, st.frm.linear, st.frm.mclk_sel)) begin
         shifted = {st.rx_shift[14:0], st.rx_s2};
         next_st.rx_shift = shifted;
         off = slot_off(st.idx, st.frm.rx_slot);
         msb = word_msb(st.frm.linear);
         if (off == msb) begin
            next_st.rx_word = st.frm.linear ? shifted : {8'h00, shifted[7:0]};
            next_st.rx_valid = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         st <= reset_state;
      end else begin
         st <= next_st;
      end
   end

   assign tx_voice_out = st.tx_out;
   assign tx_voice_oe = st.tx_oe;
   assign rx_word = st.rx_word;
   assign rx_valid = st.rx_valid;

endmodule // pvp_voice_port

// >>> design/pvp_consts.svh
`ifndef PVP_CONSTS_SVH
`define PVP_CONSTS_SVH

// Overview of operation
// - Capture receive bits only in own slot
// - Normal and delayed formats sample on falling edge
// - Reverse format samples on rising edge
// - One receive bit per master clock period
// - Drive transmit bits only in own slot
// - Transmit pin released outside own slot
// - Normal and delayed formats launch on rising edge
// - Reverse format launches on falling edge
// - Master clock is one of four rates

// Bits per frame for each master clock rate at 8 kHz framing
`define PVP_FRAME_LEN_512K 10'h040
`define PVP_FRAME_LEN_1536K 10'h0c0
`define PVP_FRAME_LEN_2048K 10'h100
`define PVP_FRAME_LEN_2560K 10'h140

// Slot width as a shift count, voice word lengths in bits and their last bit indices
`define PVP_SLOT_SHIFT 3
`define PVP_WORD_COMPANDED 10'h008
`define PVP_WORD_LINEAR 10'h010
`define PVP_MSB_COMPANDED 4'h7
`define PVP_MSB_LINEAR 4'hf

// Bit index values with special meaning
`define PVP_IDX_PENDING 10'h3ff
`define PVP_IDX_IDLE 10'h200

// Reset values
`define PVP_WORD_RESET 16'h0000
`define PVP_BIT_RESET 1'b0
`define PVP_CFG_RESET 15'h0000

`endif

// >>> design/pvp_pkg.sv
package pvp_pkg;

   typedef enum logic [1:0] {
      PVP_FMT_NORMAL = 2'h0,
      PVP_FMT_DELAYED = 2'h1,
      PVP_FMT_REVERSE = 2'h2
   } pvp_fmt_t;

   typedef enum logic [1:0] {
      PVP_MCLK_512K = 2'h0,
      PVP_MCLK_1536K = 2'h1,
      PVP_MCLK_2048K = 2'h2,
      PVP_MCLK_2560K = 2'h3
   } pvp_mclk_t;

   typedef struct packed {
      pvp_fmt_t fmt;
      pvp_mclk_t mclk_sel;
      logic linear;
      logic [4:0] rx_slot;
      logic [4:0] tx_slot;
   } pvp_cfg_t;

   typedef struct packed {
      logic mclk_s1;
      logic mclk_s2;
      logic mclk_s3;
      logic fs_s1;
      logic fs_s2;
      logic fs_prev;
      logic rx_s1;
      logic rx_s2;
      pvp_cfg_t frm;
      logic [9:0] idx;
      logic [15:0] tx_shift;
      logic [15:0] rx_shift;
      logic [15:0] rx_word;
      logic rx_valid;
      logic tx_out;
      logic tx_oe;
   } pvp_state_t;

endpackage

// >>> verification/pvp_voice_port_monitor.sv
module pvp_voice_port_monitor (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic mclk_in,
   input wire logic frame_sync_in,
   input wire pvp_pkg::pvp_cfg_t config_reg_zero,
   input wire logic tx_voice_out,
   input wire logic tx_voice_oe,
   input wire logic [15:0] rx_word,
   input wire logic rx_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   import pvp_pkg::*;
   logic rev;
   assign rev = config_reg_zero.fmt == PVP_FMT_REVERSE;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_idle_low: assert property (!tx_voice_oe |-> !tx_voice_out)
      else $error("tx high idle");
   a_word_valid: assert property ($changed(rx_word) |-> rx_valid)
      else $error("rx word no valid");
   a_tx_rise: assert property (!rev && $changed({tx_voice_oe, tx_voice_out}) |-> mclk_in)
      else $error("tx off rise");
   a_tx_fall: assert property (rev && $changed({tx_voice_oe, tx_voice_out}) |-> !mclk_in)
      else $error("tx off fall");
   a_rx_fall: assert property (!rev && rx_valid |-> !mclk_in)
      else $error("rx off fall");
   a_rx_rise: assert property (rev && rx_valid |-> mclk_in)
      else $error("rx off rise");
   a_slot_len: assert property ($rose(tx_voice_oe) |=> tx_voice_oe [*8])
      else $error("tx slot short");
   a_first_bit: assert property ($rose(tx_voice_oe) && config_reg_zero.tx_slot == 0
      |-> frame_sync_in == (config_reg_zero.fmt != PVP_FMT_DELAYED)) else $error("slot align");
   c_rev: cover property ($rose(tx_voice_oe) && rev);
   c_lin: cover property (rx_valid && config_reg_zero.linear);
   c_dly: cover property (rx_valid && config_reg_zero.fmt == PVP_FMT_DELAYED);
   c_long: cover property (rx_valid && config_reg_zero.mclk_sel != PVP_MCLK_512K);
endmodule // pvp_voice_port_monitor

bind pvp_voice_port pvp_voice_port_monitor i_mon (.clk(clk), .reset_n(reset_n),
   .mclk_in(mclk_in), .frame_sync_in(frame_sync_in), .config_reg_zero(config_reg_zero),
   .tx_voice_out(tx_voice_out), .tx_voice_oe(tx_voice_oe), .rx_word(rx_word), .rx_valid(rx_valid));

// >>> verification/pvp_highway_model.sv
module pvp_highway_model (
   input wire logic clk,
   output logic mclk_in,
   output logic frame_sync_in,
   output logic rx_voice_in,
   input wire logic tx_voice_out,
   input wire logic tx_voice_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   import pvp_pkg::*;
   initial begin
      mclk_in = 1'b0;
      frame_sync_in = 1'b0;
      rx_voice_in = 1'b0;
   end
   // Extra iterations and a short tail let a late slot close before the format may change
   task automatic run_frame(input pvp_fmt_t f, input int w, rs, ts, len,
         input logic [15:0] rb, output logic [15:0] tb, output int bad);
      int d;
      int b;
      logic rev;
      logic in_tx;
      d = (f == PVP_FMT_DELAYED);
      rev = (f == PVP_FMT_REVERSE);
      bad = 0;
      tb = 16'h0000;
      for (int i = 0; i < 74; i++) begin
         repeat (50) @(posedge clk);
         #1;
         mclk_in = rev;
         b = i - 1 - d;
         // Bits past the frame length belong to no slot
         in_tx = b >= 8 * ts && b < 8 * ts + w && b < len;
         if ((tx_voice_oe === 1'b1) != in_tx) bad++;
         if (in_tx) tb[w - 1 - (b - 8 * ts)] = tx_voice_out;
         frame_sync_in = (i == 0);
         repeat (50) @(posedge clk);
         #1;
         mclk_in = !rev;
         b = i - d;
         // Off-slot bits toggle so a stray capture cannot match by luck
         rx_voice_in = (b >= 8 * rs && b < 8 * rs + w) ? rb[w - 1 - (b - 8 * rs)] : !rx_voice_in;
      end
      // The last launch edge must be acted on before the caller may change the format
      repeat (8) @(posedge clk);
      #1;
   endtask
endmodule // pvp_highway_model

// >>> verification/pvp_voice_port_tb_top.sv
module pvp_voice_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pvp_pkg::*;
   logic clk, reset_n, mclk_in, frame_sync_in, rx_voice_in, tx_voice_out, tx_voice_oe, rx_valid;
   pvp_cfg_t cfg;
   logic [15:0] tx_word, rx_word, got, rb, rx_exp;
   int num_errors, checked, bad, seed, w, rs, ts, len, npulse, pulses;
   // Bits per frame: each master clock rate over the 8 kHz frame rate
   int lens[4] = '{64, 192, 256, 320};
   pvp_mclk_t sel;
   logic [15:0] exp_q[$];
   pvp_voice_port i_dut (.clk(clk), .reset_n(reset_n), .mclk_in(mclk_in),
      .frame_sync_in(frame_sync_in), .rx_voice_in(rx_voice_in), .config_reg_zero(cfg),
      .tx_word(tx_word), .tx_voice_out(tx_voice_out), .tx_voice_oe(tx_voice_oe),
      .rx_word(rx_word), .rx_valid(rx_valid));
   pvp_highway_model i_hw (.clk(clk), .mclk_in(mclk_in), .frame_sync_in(frame_sync_in),
      .rx_voice_in(rx_voice_in), .tx_voice_out(tx_voice_out), .tx_voice_oe(tx_voice_oe));
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(negedge clk) if (rx_valid === 1'b1) pulses++;
   initial begin
      #400000;
      num_errors++;
      finish_test;
   end
   initial begin
      seed = 32'h34529f84;
      reset_n = 1'b0;
      cfg = '0;
      tx_word = 16'h0000;
      num_errors = 0;
      checked = 0;
      npulse = 0;
      pulses = 0;
      rx_exp = 16'h0000;
      repeat (4) @(posedge clk);
      #1 reset_n = 1'b1;
      repeat (10) @(posedge clk);
      #1;
      // The last two frames put both slots past the short frame, then inside a longer one
      for (int k = 0; k < 11; k++) begin
         w = (k >= 6 && k < 9) ? 16 : 8;
         rs = k >= 9 ? 8 : $unsigned($random(seed)) % 7;
         ts = k >= 9 ? 8 : (k < 3 ? 0 : $unsigned($random(seed)) % 7);
         sel = pvp_mclk_t'(2'($random(seed)));
         if (k >= 9) sel = k == 9 ? PVP_MCLK_512K : PVP_MCLK_1536K;
         rb = 16'($random(seed));
         tx_word = 16'($random(seed));
         cfg = '{pvp_fmt_t'(k % 3), sel, w == 16, rs[4:0], ts[4:0]};
         len = lens[sel];
         if (8 * rs + w <= len) begin
            rx_exp = w == 16 ? rb : {8'h00, rb[7:0]};
            npulse++;
         end
         got = w == 16 ? tx_word : {8'h00, tx_word[7:0]};
         exp_q.push_back(8 * ts + w <= len ? got : 16'h0000);
         exp_q.push_back(rx_exp);
         i_hw.run_frame(cfg.fmt, w, rs, ts, len, rb, got, bad);
         check("tx word", got, exp_q.pop_front());
         check("rx word", rx_word, exp_q.pop_front());
         check("oe slot", 16'(bad), 16'h0000);
         check("rx pulses", 16'(pulses), 16'(npulse));
      end
      finish_test;
   end
endmodule // pvp_voice_port_tb_top
